// [logic/cs_pkg.sv]
`default_nettype none
package cs_pkg;
    // Clock and time base
    localparam int unsigned CLK_HZ        = 125_000_000;
    localparam int unsigned MS_PER_S      = 1000;
    localparam int unsigned MS_CYC        = CLK_HZ / MS_PER_S;
    // Detection windows and blink rate
    localparam int unsigned DISCH_WIN_MS  = 1000;
    localparam int unsigned PROBE_WIN_MS  = 500;
    localparam int unsigned BLINK_MHZ     = 500;
    localparam int unsigned BLINK_HALF_MS = (MS_PER_S * MS_PER_S) / (2 * BLINK_MHZ);
    // Safety timer length, arbitrary default
    localparam int unsigned SAFETY_MS     = 10_800_000;
    localparam int unsigned CNT_W         = 32;

    // Register port
    localparam int unsigned ADDR_W    = 2;
    localparam int unsigned DATA_W    = 8;
    localparam logic [1:0]  REG_STATE = 2'h0;
    localparam logic [1:0]  REG_EVENT = 2'h1;
    localparam logic [1:0]  REG_MASK  = 2'h2;

    // Event bit positions
    localparam int unsigned EV_FAULT   = 0;
    localparam int unsigned EV_ABSENT  = 1;
    localparam int unsigned EV_PRESENT = 2;
    localparam int unsigned EV_DONE    = 3;
    localparam int unsigned EV_W       = 4;
    localparam logic [EV_W-1:0] MASK_RST = 4'h0;

    // Status read layout
    localparam int unsigned ST_STATE_LSB = 0;
    localparam int unsigned ST_BLINK     = 3;
    localparam int unsigned ST_FAULT_PRB = 4;

    typedef enum logic [2:0] {
        CS_OFF,
        CS_DISCHARGE,
        CS_PROBE,
        CS_CHARGE,
        CS_FAULT_HIGH,
        CS_FAULT_LOW,
        CS_DONE
    } cs_state_t;

    // Pin-level inputs from comparators and the enable pin
    typedef struct packed {
        logic chargeEnable;
        logic aboveRecharge;
        logic belowLowVoltage;
        logic undervoltageLockout;
        logic inputOvervoltage;
        logic sleepMode;
        logic batteryOvervoltage;
        logic chargeSuspend;
        logic chargeComplete;
    } cs_sense_t;

    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } cs_bus_req_t;
endpackage
`default_nettype wire

// [logic/cs_charger_supervisor.sv]
`default_nettype none
module cs_charger_supervisor #(
    parameter int unsigned MS_CYC       = cs_pkg::MS_CYC,
    parameter int unsigned DISCH_WIN_MS = cs_pkg::DISCH_WIN_MS,
    parameter int unsigned PROBE_WIN_MS = cs_pkg::PROBE_WIN_MS,
    parameter int unsigned BLINK_HALF   = cs_pkg::BLINK_HALF_MS,
    parameter int unsigned SAFETY_MS    = cs_pkg::SAFETY_MS
) (
    // Clock and reset
    input  wire logic                      sys_clk,
    input  wire logic                      srst,
    // Analog results and enable pin
    input  wire cs_pkg::cs_sense_t         sensePins,
    // Register port
    input  wire cs_pkg::cs_bus_req_t       busReq,
    output var  logic [cs_pkg::DATA_W-1:0] rdData,
    output var  logic                      irq,
    // Open-drain indications, low when enabled
    output var  logic                      supplyValidOut,
    output var  logic                      supplyValidOe,
    output var  logic                      chargeStatusOut,
    output var  logic                      chargeStatusOe,
    // Current controls
    output var  logic                      dischargeSinkEn,
    output var  logic                      probeChargeEn,
    output var  logic                      faultProbeCurrent,
    output var  logic                      fullChargeEn
);
    localparam int unsigned SW = $bits(cs_pkg::cs_sense_t);

    logic [SW-1:0]           syncFirst;
    cs_pkg::cs_sense_t       sense;
    logic                    enablePrev;
    logic                    enableFall;
    logic [cs_pkg::CNT_W-1:0] msCnt;
    logic                    msTick;
    logic [cs_pkg::CNT_W-1:0] winCnt;
    logic [cs_pkg::CNT_W-1:0] safetyCnt;
    logic [cs_pkg::CNT_W-1:0] blinkCnt;
    logic                    blinkPhase;
    logic                    absentSeen;
    cs_pkg::cs_state_t       state;
    cs_pkg::cs_state_t       next_state;
    logic                    supplyOk;
    logic                    safetyExpired;
    logic                    winDisch;
    logic                    winProbe;
    logic                    statBlink;
    logic                    statOn;
    logic [cs_pkg::EV_W-1:0] events;
    logic [cs_pkg::EV_W-1:0] newEvents;
    logic [cs_pkg::EV_W-1:0] evMask;
    logic                    evRead;

    function automatic logic hitWindow(input logic [cs_pkg::CNT_W-1:0] cnt,
                                       input int unsigned limit);
        hitWindow = (cnt >= cs_pkg::CNT_W'(limit));
    endfunction

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            syncFirst <= '0;
            sense     <= '0;
        end else begin
            syncFirst <= sensePins;
            sense     <= cs_pkg::cs_sense_t'(syncFirst);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            enablePrev <= 1'b0;
        end else begin
            enablePrev <= sense.chargeEnable;
        end
    end
    assign enableFall = enablePrev & ~sense.chargeEnable;

    // supply valid unless lockout, overvoltage or sleep
    assign supplyOk = ~sense.undervoltageLockout & ~sense.inputOvervoltage & ~sense.sleepMode;

    // Millisecond time base
    always_ff @(posedge sys_clk) begin
        if (srst || msTick) begin
            msCnt <= '0;
        end else begin
            msCnt <= msCnt + 1'b1;
        end
    end
    assign msTick = hitWindow(msCnt, MS_CYC - 1);

    assign winDisch      = hitWindow(winCnt, DISCH_WIN_MS);
    assign winProbe      = hitWindow(winCnt, PROBE_WIN_MS);
    assign safetyExpired = hitWindow(safetyCnt, SAFETY_MS);

    always_comb begin
        next_state = state;
        unique case (state)
            cs_pkg::CS_OFF: begin
                if (sense.chargeEnable) begin
                    next_state = cs_pkg::CS_DISCHARGE;
                end
            end
            cs_pkg::CS_DISCHARGE: begin
                if (sense.belowLowVoltage) begin
                    next_state = cs_pkg::CS_PROBE;
                end else if (winDisch) begin
                    next_state = cs_pkg::CS_CHARGE;
                end
            end
            cs_pkg::CS_PROBE: begin
                if (sense.aboveRecharge) begin
                    next_state = cs_pkg::CS_DISCHARGE;
                end else if (winProbe) begin
                    next_state = cs_pkg::CS_CHARGE;
                end
            end
            cs_pkg::CS_CHARGE: begin
                if (sense.chargeComplete) begin
                    next_state = cs_pkg::CS_DONE;
                end else if (safetyExpired) begin
                    next_state = sense.aboveRecharge ? cs_pkg::CS_FAULT_HIGH
                                                     : cs_pkg::CS_FAULT_LOW;
                end
            end
            cs_pkg::CS_FAULT_HIGH: begin
                if (!sense.aboveRecharge) begin
                    next_state = cs_pkg::CS_DISCHARGE;
                end
            end
            cs_pkg::CS_FAULT_LOW: begin
                if (sense.aboveRecharge) begin
                    next_state = cs_pkg::CS_FAULT_HIGH;
                end
            end
            cs_pkg::CS_DONE: begin
                if (!sense.aboveRecharge) begin
                    next_state = cs_pkg::CS_DISCHARGE;
                end
            end
            default: begin
                next_state = cs_pkg::CS_OFF;
            end
        endcase
        if (sense.undervoltageLockout || !sense.chargeEnable) begin
            next_state = cs_pkg::CS_OFF;
        end
    end

    // reset or enable low clears faults
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            state <= cs_pkg::CS_OFF;
        end else begin
            state <= next_state;
        end
    end

    // Detection window counter, restarts on every state change
    always_ff @(posedge sys_clk) begin
        if (srst || enableFall || next_state != state) begin
            winCnt <= '0;
        end else if (msTick && !winDisch) begin
            winCnt <= winCnt + 1'b1;
        end
    end

    // Safety timer runs only while charging
    always_ff @(posedge sys_clk) begin
        if (srst || enableFall || state != cs_pkg::CS_CHARGE) begin
            safetyCnt <= '0;
        // pause, keep count, on overvoltage or suspend
        end else if (msTick && !safetyExpired && !sense.batteryOvervoltage
                     && !sense.chargeSuspend) begin
            safetyCnt <= safetyCnt + 1'b1;
        end
    end

    // one second on, one second off
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            blinkCnt   <= '0;
            blinkPhase <= 1'b0;
        end else if (msTick) begin
            if (hitWindow(blinkCnt, BLINK_HALF - 1)) begin
                blinkCnt   <= '0;
                blinkPhase <= ~blinkPhase;
            end else begin
                blinkCnt <= blinkCnt + 1'b1;
            end
        end
    end

    // Battery judged absent until a later detection finds one
    always_ff @(posedge sys_clk) begin
        if (srst || enableFall || next_state == cs_pkg::CS_OFF) begin
            absentSeen <= 1'b0;
        end else if (state == cs_pkg::CS_PROBE && sense.aboveRecharge) begin
            absentSeen <= 1'b1;
        end else if (next_state == cs_pkg::CS_CHARGE) begin
            absentSeen <= 1'b0;
        end
    end

    // blink on suspend, fault, overvoltage, absent
    assign statBlink = sense.chargeSuspend || sense.inputOvervoltage || absentSeen
                       || state == cs_pkg::CS_FAULT_HIGH || state == cs_pkg::CS_FAULT_LOW;
    assign statOn    = state == cs_pkg::CS_CHARGE && !sense.sleepMode;

    // Registered pin drives
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            supplyValidOut    <= 1'b0;
            chargeStatusOut   <= 1'b0;
            supplyValidOe     <= 1'b0;
            chargeStatusOe    <= 1'b0;
            dischargeSinkEn   <= 1'b0;
            probeChargeEn     <= 1'b0;
            faultProbeCurrent <= 1'b0;
            fullChargeEn      <= 1'b0;
        end else begin
            // Open-drain data stays low; only the enables move
            supplyValidOut    <= 1'b0;
            chargeStatusOut   <= 1'b0;
            supplyValidOe     <= supplyOk;
            // status on, off or blinking
            // Input overvoltage must still blink, so only lockout and sleep blank it
            chargeStatusOe    <= !sense.undervoltageLockout && !sense.sleepMode
                                 && (statBlink ? blinkPhase : statOn);
            dischargeSinkEn   <= state == cs_pkg::CS_DISCHARGE;
            probeChargeEn     <= state == cs_pkg::CS_PROBE && supplyOk;
            faultProbeCurrent <= state == cs_pkg::CS_FAULT_LOW && !sense.aboveRecharge;
            // full charge only when all conditions hold
            fullChargeEn      <= state == cs_pkg::CS_CHARGE && supplyOk
                                 && sense.chargeEnable && !sense.chargeSuspend
                                 && !sense.batteryOvervoltage && !sense.chargeComplete;
        end
    end
    // Event capture
    always_comb begin
        newEvents = '0;
        newEvents[cs_pkg::EV_FAULT]   = state == cs_pkg::CS_CHARGE
                                        && (next_state == cs_pkg::CS_FAULT_HIGH
                                            || next_state == cs_pkg::CS_FAULT_LOW);
        newEvents[cs_pkg::EV_ABSENT]  = state == cs_pkg::CS_PROBE
                                        && next_state == cs_pkg::CS_DISCHARGE;
        newEvents[cs_pkg::EV_PRESENT] = state != cs_pkg::CS_CHARGE
                                        && next_state == cs_pkg::CS_CHARGE;
        newEvents[cs_pkg::EV_DONE]    = state == cs_pkg::CS_CHARGE
                                        && next_state == cs_pkg::CS_DONE;
    end

    assign evRead = busReq.rd && busReq.addr == cs_pkg::REG_EVENT;

    // Sticky events, a read clears; a new event wins
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            events <= '0;
        end else begin
            events <= (evRead ? '0 : events) | newEvents;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            evMask <= cs_pkg::MASK_RST;
        end else if (busReq.wr && busReq.addr == cs_pkg::REG_MASK) begin
            evMask <= busReq.wdata[cs_pkg::EV_W-1:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(((evRead ? '0 : events) | newEvents) & evMask);
        end
    end

    // Read data one cycle after the strobe, zero otherwise
    always_ff @(posedge sys_clk) begin
        if (srst || !busReq.rd) begin
            rdData <= '0;
        end else begin
            rdData <= '0;
            unique case (busReq.addr)
                cs_pkg::REG_STATE: begin
                    rdData[cs_pkg::ST_STATE_LSB +: 3] <= 3'(state);
                    rdData[cs_pkg::ST_BLINK]          <= statBlink;
                    rdData[cs_pkg::ST_FAULT_PRB]      <= faultProbeCurrent;
                end
                cs_pkg::REG_EVENT: begin
                    rdData[cs_pkg::EV_W-1:0] <= events;
                end
                cs_pkg::REG_MASK: begin
                    rdData[cs_pkg::EV_W-1:0] <= evMask;
                end
                default: begin
                    rdData <= '0;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// [test/cs_charger_supervisor_monitor.sv]
`default_nettype none
module cs_charger_supervisor_monitor #(
    parameter int unsigned MS_CYC       = 4,
    parameter int unsigned DISCH_WIN_MS = 5,
    parameter int unsigned PROBE_WIN_MS = 3
) (
    // Clock and reset
    input wire logic              sys_clk,
    input wire logic              srst,
    // Pins in
    input wire cs_pkg::cs_sense_t sensePins,
    // Pins out
    input wire logic              supplyValidOe,
    input wire logic              chargeStatusOe,
    input wire logic              dischargeSinkEn,
    input wire logic              probeChargeEn,
    input wire logic              faultProbeCurrent,
    input wire logic              fullChargeEn
);
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (srst);
    logic        run;
    logic        good;
    logic        anyOn;
    logic [31:0] sinkCyc;
    logic [31:0] probeCyc;
    assign run   = sensePins.chargeEnable && !sensePins.undervoltageLockout;
    assign good  = !(sensePins.undervoltageLockout || sensePins.inputOvervoltage
                     || sensePins.sleepMode);
    assign anyOn = dischargeSinkEn || probeChargeEn || fullChargeEn || faultProbeCurrent;
    // Length of each detection step
    always_ff @(posedge sys_clk) begin
        sinkCyc <= dischargeSinkEn ? sinkCyc + 32'h1 : 32'h0;
    end
    always_ff @(posedge sys_clk) begin
        probeCyc <= probeChargeEn ? probeCyc + 32'h1 : 32'h0;
    end
    sequence s_enRise;
        (!sensePins.chargeEnable)[*5] ##1 (run && good)[*4];
    endsequence
    sequence s_charging;
        (fullChargeEn && good && !sensePins.chargeSuspend)[*6];
    endsequence
    chk_sink_start: assert property (s_enRise |-> ##[0:2] dischargeSinkEn)
        else $error("Sink late after enable");
    chk_enable_off: assert property ((!sensePins.chargeEnable)[*5] |-> !anyOn)
        else $error("Current on with enable low");
    chk_lockout_off: assert property (sensePins.undervoltageLockout[*5] |-> !anyOn)
        else $error("Current on in lockout");
    chk_supply_on: assert property (good[*6] |-> supplyValidOe)
        else $error("Supply valid not shown");
    chk_supply_off: assert property ((!good)[*6] |-> !supplyValidOe)
        else $error("Supply valid shown wrongly");
    chk_probe_swap: assert property (probeChargeEn |-> !dischargeSinkEn)
        else $error("Probe and sink on together");
    chk_charge_entry: assert property (fullChargeEn |->
        !(dischargeSinkEn || probeChargeEn || faultProbeCurrent))
        else $error("Charge on beside a detection current");
    chk_disch_window: assert property (sinkCyc <= DISCH_WIN_MS * MS_CYC + 2)
        else $error("Discharge window overrun");
    chk_probe_window: assert property (probeCyc <= PROBE_WIN_MS * MS_CYC + 2)
        else $error("Probe window overrun");
    chk_fprobe_above: assert property ((run && sensePins.aboveRecharge)[*5] |->
        !faultProbeCurrent)
        else $error("Fault probe on above recharge");
    chk_status_on: assert property (s_charging |-> chargeStatusOe)
        else $error("Status off while charging");
endmodule
bind cs_charger_supervisor cs_charger_supervisor_monitor #(
    .MS_CYC(MS_CYC), .DISCH_WIN_MS(DISCH_WIN_MS), .PROBE_WIN_MS(PROBE_WIN_MS)
) u_cs_monitor (
    .sys_clk, .srst, .sensePins, .supplyValidOe, .chargeStatusOe,
    .dischargeSinkEn, .probeChargeEn, .faultProbeCurrent, .fullChargeEn
);
`default_nettype wire

// [test/cs_battery_model.sv]
`default_nettype none
module cs_battery_model (
    // Clock
    input  wire logic       sys_clk,
    // Pack set by the bench
    input  wire logic       present,
    input  wire logic       slow,
    input  wire logic [1:0] packLvl,
    // Currents from the charger
    input  wire logic       sinkOn,
    input  wire logic       feedOn,
    // Comparator results
    output var  logic       aboveRecharge,
    output var  logic       belowLowVoltage
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] lvl  = 2'h1;
    logic [1:0] pace = 2'h0;
    // Empty socket follows the currents; slow one moves every fourth cycle
    always @(posedge sys_clk) begin
        pace <= pace + 2'h1;
        if (present) begin
            lvl <= packLvl;
        end else if (!slow || pace == 2'h3) begin
            if (sinkOn) begin
                lvl <= 2'h0;
            end else if (feedOn) begin
                lvl <= 2'h2;
            end
        end
    end
    assign aboveRecharge   = lvl == 2'h2;
    assign belowLowVoltage = lvl == 2'h0;
endmodule
`default_nettype wire

// [test/cs_charger_supervisor_tb.sv]
`default_nettype none
module cs_charger_supervisor_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned MSC = 4;
    localparam int unsigned BH  = 2;
    logic                sys_clk = 1'b0;
    logic                srst    = 1'b1;
    logic                en, above, below, lockout, ovp, slp, bov, susp, cmpl;
    logic                present, slow, irq, svOut, svOe, stOut, stOe;
    logic [1:0]          packLvl;
    logic [3:0]          outs;
    logic [7:0]          rdData, d;
    logic [31:0]         rs;
    int                  errCount = 0;
    int                  cmpCount = 0;
    int                  n;
    cs_pkg::cs_sense_t   sense;
    cs_pkg::cs_bus_req_t req;
    wire logic           svPin = svOe ? svOut : 1'b1;
    wire logic           stPin = stOe ? stOut : 1'b1;
    assign sense = {en, above, below, lockout, ovp, slp, bov, susp, cmpl};
    cs_charger_supervisor #(.MS_CYC(MSC), .DISCH_WIN_MS(5), .PROBE_WIN_MS(3),
        .BLINK_HALF(BH), .SAFETY_MS(10)) u_cs_charger_supervisor (
        .sys_clk, .srst, .sensePins(sense), .busReq(req), .rdData, .irq,
        .supplyValidOut(svOut), .supplyValidOe(svOe), .chargeStatusOut(stOut),
        .chargeStatusOe(stOe), .dischargeSinkEn(outs[0]), .probeChargeEn(outs[1]),
        .fullChargeEn(outs[2]), .faultProbeCurrent(outs[3]));
    cs_battery_model u_cs_battery_model (.sys_clk, .present, .slow, .packLvl,
        .sinkOn(outs[0]), .feedOn(|outs[3:1]), .aboveRecharge(above),
        .belowLowVoltage(below));
    initial begin
        forever #4 sys_clk = ~sys_clk;
    end
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    function automatic logic [7:0] evMask(input int b);
        return 8'(1 << b);
    endfunction
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        cmpCount++;
        if (s !== e) begin
            errCount++;
            $display("ERROR at %0t: got %h, expected %h", $time, s, e);
        end
    endtask
    task automatic reportAndStop();
        $display("Compares %0d, mismatches %0d", cmpCount, errCount);
        if (errCount == 0 && cmpCount > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge sys_clk);
    endtask
    task automatic wrReg(input logic [1:0] a, input logic [7:0] v);
        @(posedge sys_clk);
        req.wr <= 1'b1;
        req.addr <= a;
        req.wdata <= v;
        @(posedge sys_clk);
        req.wr <= 1'b0;
    endtask
    task automatic rdReg(input logic [1:0] a);
        @(posedge sys_clk);
        req.rd <= 1'b1;
        req.addr <= a;
        @(posedge sys_clk);
        req.rd <= 1'b0;
        #1 d = rdData;
    endtask
    task automatic chkSt(input cs_pkg::cs_state_t s);
        rdReg(cs_pkg::REG_STATE);
        chk(d & 8'h07, {5'h0, s});
    endtask
    task automatic chkEv(input int b);
        rdReg(cs_pkg::REG_EVENT);
        chk(d & evMask(b), evMask(b));
    endtask
    task automatic waitOut(input int i, input logic v);
        for (int k = 0; outs[i] !== v; k++) begin
            if (k > 300) begin
                errCount++;
                $display("ERROR at %0t: output wait ran out", $time);
                reportAndStop();
            end
            @(posedge sys_clk);
            #1;
        end
    endtask
    task automatic blink();
        n = 0;
        repeat (4 * BH * MSC) begin
            @(posedge sys_clk);
            #1 n += int'(stPin === 1'b0);
        end
        chk(8'(n), 8'(2 * BH * MSC));
    endtask
    initial begin
        req = '0;
        {en, lockout, ovp, slp, bov, susp, cmpl, slow} = '0;
        present = 1'b1;
        packLvl = 2'h2;
        rs = 32'h7030c05b;
        tick(8);
        srst <= 1'b0;
        wrReg(2'h3, 8'hff);
        wrReg(cs_pkg::REG_STATE, 8'hff);
        rdReg(2'h3);
        chk(d, 8'h00);
        rdReg(cs_pkg::REG_MASK);
        chk(d, {4'h0, cs_pkg::MASK_RST});
        chkSt(cs_pkg::CS_OFF);
        chk({4'h0, outs}, 8'h00);
        repeat (3) begin
            rs = xs(rs);
            wrReg(cs_pkg::REG_MASK, rs[7:0]);
            rdReg(cs_pkg::REG_MASK);
            chk(d, {4'h0, rs[3:0]});
        end
        for (int k = 0; k < 4; k++) begin
            tick(1);
            {lockout, ovp, slp} <= 3'h4 >> k;
            tick(6);
            #1 chk({7'h0, svPin}, {7'h0, k != 3});
        end
        tick(1);
        ovp <= 1'b1;
        tick(6);
        blink();
        tick(1);
        ovp <= 1'b0;
        wrReg(cs_pkg::REG_MASK, evMask(cs_pkg::EV_PRESENT));
        rdReg(cs_pkg::REG_EVENT);
        tick(1);
        en <= 1'b1;
        waitOut(0, 1'b1);
        waitOut(2, 1'b1);
        chk({4'h0, outs}, 8'h04);
        tick(2);
        #1 chk({7'h0, irq}, 8'h01);
        chkEv(cs_pkg::EV_PRESENT);
        chk({7'h0, irq | stPin}, 8'h00);
        tick(1);
        cmpl <= 1'b1;
        tick(6);
        chkSt(cs_pkg::CS_DONE);
        chk({7'h0, stPin}, 8'h01);
        tick(1);
        cmpl <= 1'b0;
        packLvl <= 2'h1;
        waitOut(0, 1'b1);
        waitOut(3, 1'b1);
        chkSt(cs_pkg::CS_FAULT_LOW);
        chk({7'h0, irq}, 8'h01);
        chkEv(cs_pkg::EV_FAULT);
        chk({7'h0, irq}, 8'h00);
        tick(20);
        #1 chk({4'h0, outs}, 8'h08);
        tick(1);
        packLvl <= 2'h2;
        waitOut(3, 1'b0);
        chkSt(cs_pkg::CS_FAULT_HIGH);
        blink();
        tick(1);
        packLvl <= 2'h1;
        waitOut(0, 1'b1);
        waitOut(2, 1'b1);
        tick(1);
        bov <= 1'b1;
        tick(60);
        chkSt(cs_pkg::CS_CHARGE);
        tick(1);
        bov <= 1'b0;
        waitOut(3, 1'b1);
        tick(1);
        en <= 1'b0;
        tick(6);
        chkSt(cs_pkg::CS_OFF);
        chk({4'h0, outs}, 8'h00);
        tick(1);
        {present, slow, en} <= 3'b011;
        waitOut(1, 1'b1);
        waitOut(0, 1'b1);
        chkEv(cs_pkg::EV_ABSENT);
        blink();
        tick(1);
        lockout <= 1'b1;
        tick(6);
        chkSt(cs_pkg::CS_OFF);
        chk({4'h0, outs}, 8'h00);
        tick(1);
        {lockout, present, slow} <= 3'b010;
        repeat (40) begin
            rs = xs(rs);
            packLvl <= rs[1] ? 2'h2 : {1'b0, rs[0]};
            {susp, ovp, cmpl, bov} <= rs[5:2] & {4{rs[6]}};
            {lockout, slp} <= rs[8:7] & {2{rs[9] & rs[10]}};
            en <= rs[12:11] != 2'h0;
            tick(5 + int'(rs[16:13]));
        end
        reportAndStop();
    end
endmodule
`default_nettype wire
